// *** fbc_reporter.sv ***
/*
  Fault memory and blink-code readout. Stores two-digit codes from the
  fault detectors, heals them when faults go away, detects the key-switch
  request and flashes the codes on the fault lamp, ending with 61.
  Assumes detector and key inputs are synchronous to i_clock and that a
  supply loss reaches this block as i_rst.
*/
`timescale 1ns/100ps
`default_nettype none

module fbc_reporter
  import fbc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int unsigned MIX_QUAL_MS = MIX_QUAL_MS_DFLT
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Key switch and engine state
  input wire logic i_key_on,
  input wire logic i_engine_running,
  // Fault detectors
  input wire logic i_loss_sync,
  input wire logic i_tps_open_gnd,
  input wire logic i_tps_short_bat,
  input wire logic i_controller_defect,
  input wire logic i_speed_sensor_fault,
  input wire logic i_too_lean,
  input wire logic i_mix_upper_limit,
  input wire logic i_adapt_limit,
  // Lamp and status
  output logic o_fault_indicator_lamp,
  output logic o_readout_active,
  output logic [6:0] o_stored_codes
);

  // Slot to code, tens digit in the high nibble
  function automatic logic [7:0] code_of(input logic [2:0] idx);
    logic [7:0] c;
    c = CODE_END;
    unique case (idx)
      3'h0: c = 8'h21;
      3'h1: c = 8'h22;
      3'h2: c = 8'h23;
      3'h3: c = 8'h24;
      3'h4: c = 8'h31;
      3'h5: c = 8'h33;
      3'h6: c = 8'h34;
      3'h7: c = CODE_END;
    endcase
    return c;
  endfunction

  fbc_state_t st;
  fbc_state_t nx;
  logic [6:0] faults;
  logic mix_ok;
  logic [2:0] cnt;
  logic [7:0] code_sel;

  always_comb
  begin
    nx = st;
    faults = '0;
    cnt = st.key_count;
    code_sel = code_of(st.idx);
    mix_ok = (st.run_ms >= 20'(MIX_QUAL_MS));
    // Free-running timebase
    nx.tick = 1'b0;
    if (st.tick_cnt == 16'(TICK_CYCLES - 1))
    begin
      nx.tick_cnt = '0;
      nx.tick = 1'b1;
    end
    else
    begin
      nx.tick_cnt = st.tick_cnt + 16'h0001;
    end
    if (!i_engine_running)
    begin
      nx.run_ms = '0;
    end
    else if (st.tick && !mix_ok)
    begin
      nx.run_ms = st.run_ms + 20'h00001;
    end

    // Implausible sensor signal has no input: never reported
    faults[0] = i_loss_sync;
    faults[1] = i_tps_open_gnd | i_tps_short_bat;
    faults[2] = i_controller_defect;
    faults[3] = i_speed_sensor_fault;
    faults[4] = i_too_lean;
    faults[5] = i_mix_upper_limit;
    faults[6] = i_adapt_limit;
    // Mixture detectors settle slowly, so gate them on run time
    faults = faults & (mix_ok ? 7'h7F : ~MIX_SLOTS);

    for (int k = 0; k < NUM_SLOTS; k++)
    begin
      if (faults[k])
      begin
        nx.store[k] = 1'b1;
        nx.heal[k] = '0;
      end
      else if (st.store[k])
      begin
        if (st.heal[k] == HEAL_MS)
        begin
          nx.store[k] = 1'b0;
          nx.heal[k] = '0;
        end
        else if (st.tick)
        begin
          nx.heal[k] = st.heal[k] + 12'h001;
        end
      end
    end

    // Readout sequencer
    if (st.tick && st.timer != '0)
    begin
      nx.timer = st.timer - 12'h001;
    end
    unique case (st.mode)
      S_IDLE:
      begin
        nx.idx = '0;
      end
      S_SCAN:
      begin
        if (st.idx == END_IDX || st.snap[st.idx])
        begin
          // First stored slot wins; order is slot order, which is also ascending numeric
          nx.cur = code_sel;
          nx.left = code_sel[7:4];
          nx.units = 1'b0;
          nx.timer = BLINK_ON_MS;
          nx.mode = S_ON;
        end
        else
        begin
          nx.idx = st.idx + 3'h1;
        end
      end
      S_ON:
      begin
        if (st.timer == '0)
        begin
          nx.left = st.left - 4'h1;
          nx.timer = BLINK_OFF_MS;
          nx.mode = S_OFF;
        end
      end
      S_OFF:
      begin
        if (st.timer == '0)
        begin
          if (st.left != '0)
          begin
            nx.timer = BLINK_ON_MS;
            nx.mode = S_ON;
          end
          else if (!st.units)
          begin
            nx.units = 1'b1;
            nx.left = st.cur[3:0];
            nx.timer = DIGIT_PAUSE_MS;
            nx.mode = S_PAUSE;
          end
          else
          begin
            nx.timer = CODE_GAP_MS;
            nx.mode = S_GAP;
          end
        end
      end
      S_PAUSE:
      begin
        if (st.timer == '0)
        begin
          nx.timer = BLINK_ON_MS;
          nx.mode = S_ON;
        end
      end
      S_GAP:
      begin
        if (st.timer == '0)
        begin
          if (st.idx == END_IDX)
          begin
            nx.mode = S_IDLE;
          end
          else
          begin
            nx.idx = st.idx + 3'h1;
            nx.mode = S_SCAN;
          end
        end
      end
    endcase

    // Key request detector
    nx.key_prev = i_key_on;
    if (st.tick && st.gap_ms != 12'hFFF)
    begin
      nx.gap_ms = st.gap_ms + 12'h001;
    end
    if (i_key_on != st.key_prev)
    begin
      nx.gap_ms = '0;
      if (st.key_count == '0 || st.gap_ms >= KEY_GAP_MS)
      begin
        cnt = i_key_on ? 3'h1 : 3'h0;
      end
      else
      begin
        cnt = st.key_count + 3'h1;
      end
      if (st.mode != S_IDLE)
      begin
        cnt = '0;
        // Key off mid-readout abandons it
        if (!i_key_on)
        begin
          nx.mode = S_IDLE;
        end
      end
      else if (cnt == KEY_EDGES)
      begin
        cnt = '0;
        nx.snap = st.store;
        nx.idx = '0;
        nx.mode = S_SCAN;
      end
      nx.key_count = cnt;
    end

    nx.lamp = (nx.mode == S_IDLE) ? |nx.store : (nx.mode == S_ON);
    nx.active = (nx.mode != S_IDLE);
  end

  // Supply loss clears the whole memory
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign o_fault_indicator_lamp = st.lamp;
  assign o_readout_active = st.active;
  assign o_stored_codes = st.store;

  a_fault_records: assert property (
    @(posedge i_clock) disable iff (i_rst)
    i_loss_sync |=> st.store[0] ##1 (st.mode != S_IDLE || o_fault_indicator_lamp))
    else $error("sync loss not stored or lamp dark");

  a_heal_clears: assert property (
    @(posedge i_clock) disable iff (i_rst)
    $fell(st.store[0]) |-> $past(st.heal[0]) == HEAL_MS && !$past(i_loss_sync))
    else $error("code cleared before heal time");

  a_tps_both: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_tps_short_bat || i_tps_open_gnd) |=> st.store[1])
    else $error("throttle sensor fault not stored as 22");

  a_mix_gated: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (st.run_ms < 20'(MIX_QUAL_MS) && !st.store[5]) |=> !st.store[5])
    else $error("mixture code stored before run time");

  a_start_seq: assert property (
    @(posedge i_clock) disable iff (i_rst)
    $rose(o_readout_active) |-> $past(st.key_count) == 3'h4
      && $past(st.gap_ms) < KEY_GAP_MS && $past(i_key_on))
    else $error("readout started without valid key sequence");

  a_digit_range: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (st.mode == S_ON) |-> st.cur[7:4] >= 4'h2 && st.cur[7:4] <= 4'h6
      && st.cur[3:0] >= 4'h1 && st.cur[3:0] <= 4'h6)
    else $error("code digit out of range");

  a_end_code: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (st.mode == S_GAP && i_key_on && st.key_prev ##1 st.mode == S_IDLE)
      |-> $past(st.cur) == CODE_END)
    else $error("readout ended without code 61");

  a_empty_end: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (st.mode == S_SCAN && st.idx == 3'h0 && st.snap == '0 && i_key_on)
      |-> ##[1:10] st.mode == S_ON && st.cur == CODE_END)
    else $error("empty memory did not flash 61 at once");

  a_tick_period: assert property (
    @(posedge i_clock) disable iff (i_rst)
    st.tick |-> st.tick_cnt == 16'h0000 ##1 !st.tick)
    else $error("timebase tick malformed");

endmodule

`default_nettype wire

// *** fbc_pkg.sv ***
/*
  Constants, codes and state types for the fault memory and blink-code
  readout block. Assumes a single 50 MHz clock and that all times are
  measured on a 1 ms tick made from that clock.
*/
// Overview of operation
// - A detected fault out of limits lights the fault lamp and is stored in fault memory.
// - A stored code clears itself once its fault has stayed away long enough; the lamp goes off once no code is stored.
// - Each stored fault is held as a two-digit decimal code.
// - Every gap between key transitions must be under 2.5 s, or no readout starts.
// - Each code flashes a tens group of 2 to 6 blinks, a pause, then a units group of 1 to 6.
// - Stored codes may come out in any order.
// - Code 61 is the last code of every readout not abandoned by key off.
// - With nothing stored, only code 61 is flashed, straight away.
// - Loss of supply (reset) erases all codes and leaves the lamp off until a new fault or a readout request.
// - Mixture and adaption codes 31, 33, 34 are detected only after a long engine run.
// - Throttle position sensor open, shorted to ground or to battery all give code 22.
// - An implausible throttle position sensor signal is never reported.
package fbc_pkg;

  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES_DFLT = (CLOCK_HZ / 1_000_000) * TICK_TIME_US;

  // All durations below are counted in 1 ms ticks
  localparam logic [11:0] KEY_GAP_MS = 12'h9C4;
  localparam logic [11:0] BLINK_ON_MS = 12'h190;
  localparam logic [11:0] BLINK_OFF_MS = 12'h190;
  localparam logic [11:0] DIGIT_PAUSE_MS = 12'h4B0;
  localparam logic [11:0] CODE_GAP_MS = 12'h9C4;
  localparam logic [11:0] HEAL_MS = 12'hBB8;
  localparam int unsigned MIX_QUAL_MS_DFLT = 600_000;

  localparam int unsigned NUM_SLOTS = 7;
  localparam logic [2:0] END_IDX = 3'h7;
  localparam logic [2:0] KEY_EDGES = 3'h5;
  localparam logic [6:0] MIX_SLOTS = 7'h70;
  localparam logic [7:0] CODE_END = 8'h61;

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_ON, S_OFF, S_PAUSE, S_GAP} fbc_mode_t;

  typedef struct packed {
    fbc_mode_t mode;
    logic [15:0] tick_cnt;
    logic tick;
    logic [19:0] run_ms;
    logic [6:0] store;
    logic [6:0] snap;
    logic [6:0][11:0] heal;
    logic key_prev;
    logic [2:0] key_count;
    logic [11:0] gap_ms;
    logic [11:0] timer;
    logic [2:0] idx;
    logic [7:0] cur;
    logic [3:0] left;
    logic units;
    logic lamp;
    logic active;
  } fbc_state_t;

endpackage

// *** fbc_operator.sv ***
/*
  Operator model: key switch and lamp reader.
  Assumes the bench calls its tasks; the key moves at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none

module fbc_operator
(
  // Clock and lamp
  input wire logic i_clock,
  input wire logic i_lamp,
  // Key switch
  output logic o_key_on
);
  initial o_key_on = 1'b0;

  // First gap long so an earlier half sequence is forgotten
  task automatic request(input int gap, input int slow_at, input int slow);
    int i;
    for (i = 0; i < 5; i++)
    begin
      repeat ((i == 0 || i == slow_at) ? slow : gap) @(negedge i_clock);
      o_key_on = ~o_key_on;
    end
  endtask

  task automatic key_off();
    @(negedge i_clock);
    o_key_on = 1'b0;
  endtask

  // A group ends once the lamp stays dark well past a blink off time
  task automatic read_group(output int n);
    int low;
    int t;
    logic prev;
    n = 0;
    low = 0;
    prev = 1'b0;
    for (t = 0; t < 16000 && (n == 0 || low < 1300); t++)
    begin
      @(negedge i_clock);
      if (i_lamp === 1'b1 && !prev)
        n++;
      low = (i_lamp === 1'b1) ? 0 : low + 1;
      prev = (i_lamp === 1'b1);
    end
  endtask
endmodule

`default_nettype wire

// *** test_fbc_reporter.sv ***
/*
  Bench for the fault blink-code reporter.
  Assumes the operator model fbc_operator; 1 ms tick is 2 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module test_fbc_reporter;
  import fbc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst;
  logic i_engine_running;
  logic [7:0] det;
  wire logic key;
  wire logic lamp;
  wire logic act;
  wire logic [6:0] codes;
  int bad_count;
  int n_tests;

  fbc_reporter #(.TICK_CYCLES(2), .MIX_QUAL_MS(20)) dut_u
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_key_on(key),
    .i_engine_running(i_engine_running),
    .i_loss_sync(det[0]),
    .i_tps_open_gnd(det[1]),
    .i_tps_short_bat(det[2]),
    .i_controller_defect(det[3]),
    .i_speed_sensor_fault(det[4]),
    .i_too_lean(det[5]),
    .i_mix_upper_limit(det[6]),
    .i_adapt_limit(det[7]),
    .o_fault_indicator_lamp(lamp),
    .o_readout_active(act),
    .o_stored_codes(codes)
  );

  fbc_operator op_u
  (
    .i_clock(i_clock),
    .i_lamp(lamp),
    .o_key_on(key)
  );

  task automatic chk(input string s, input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic chkn(input string s, input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", s, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_reset();
    i_rst = 1'b1;
    cyc(2);
    chk("codes", codes, 7'h00);
    chk("lamp", 7'(lamp), 7'h00);
    i_rst = 1'b0;
    cyc(2);
    chk("lamp", 7'(lamp), 7'h00);
  endtask

  // Earlier codes stay stored while later detectors fire
  task automatic t_store();
    logic [6:0] exp [5] = '{7'h01, 7'h03, 7'h03, 7'h07, 7'h0F};
    int i;
    for (i = 0; i < 5; i++)
    begin
      det = 8'h01 << i;
      cyc(3);
      chk("codes", codes, exp[i]);
      chk("lamp", 7'(lamp), 7'h01);
    end
    det = 8'h00;
    cyc(5800);
    chk("codes", codes, 7'h0F);
    cyc(300);
    chk("codes", codes, 7'h00);
    chk("lamp", 7'(lamp), 7'h00);
  endtask

  task automatic t_mix();
    det = 8'hE0;
    cyc(100);
    chk("codes", codes, 7'h00);
    i_engine_running = 1'b1;
    cyc(60);
    chk("codes", codes, MIX_SLOTS);
    det = 8'h00;
    i_engine_running = 1'b0;
    t_reset();
  endtask

  task automatic t_readout(input logic [7:0] d, input int tens, input int units);
    int n;
    int t;
    det = d;
    op_u.request(1000, 0, 5200);
    cyc(4);
    chk("active", 7'(act), 7'h01);
    if (tens != 0)
    begin
      op_u.read_group(n);
      chkn("tens", n, tens);
      op_u.read_group(n);
      chkn("units", n, units);
    end
    op_u.read_group(n);
    chkn("end tens", n, 6);
    op_u.read_group(n);
    chkn("end units", n, 1);
    for (t = 0; t < 7000 && act !== 1'b0; t++)
      cyc(1);
    chk("active", 7'(act), 7'h00);
    det = 8'h00;
    op_u.key_off();
  endtask

  task automatic t_slow();
    op_u.request(1000, 3, 5200);
    cyc(20);
    chk("active", 7'(act), 7'h00);
    op_u.key_off();
  endtask

  // Clock starts low at declaration so time zero gives no false falling edge
  initial
  begin
    forever #10 i_clock = ~i_clock;
  end

  // About 89k cycles expected
  initial
  begin
    #2_000_000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    bad_count = 0;
    n_tests = 0;
    det = 8'h00;
    i_engine_running = 1'b0;
    t_reset();
    t_store();
    t_mix();
    t_readout(8'h00, 0, 0);
    t_readout(8'h02, 2, 2);
    t_slow();
    complete_run();
  end
endmodule

`default_nettype wire
